// >>> design/cod_regs.svh
// Register offsets, field positions, reset values and timing for the output clock block.
// Assumes 32-bit Avalon-MM byte addressing with one register per aligned word.
`ifndef COD_REGS_SVH
`define COD_REGS_SVH

`define COD_NUM_OUT 4
`define COD_ADDR_W 8

`define COD_CTRL_OFS 8'h00
`define COD_STATUS_OFS 8'h04
`define COD_OUT_CFG_HI 4'h1

`define COD_CTRL_OE_SEL 0
`define COD_CTRL_STARTUP_GATE 1
`define COD_CTRL_DIV_SYNC 2
`define COD_CTRL_RESET 2'h2

`define COD_F_RATIO_LSB 0
`define COD_F_TYPE_LSB 8
`define COD_F_LEG_LSB 10
`define COD_F_DISST_LSB 12
`define COD_F_PD 14
`define COD_F_DIS 15
`define COD_F_HSW_LSB 16
`define COD_F_LAMP_LSB 20
`define COD_CFG_W 24
`define COD_CFG_RESET 24'h000C04

`define COD_TYPE_HCSL 2'h0
`define COD_TYPE_LVDS 2'h1
`define COD_TYPE_LVCMOS 2'h2
`define COD_DIS_LOW 2'h0
`define COD_DIS_HIGH 2'h1
`define COD_DIS_TRI 2'h2
`define COD_LEG_TRUE 0
`define COD_LEG_COMP 1

`define COD_ST_EN_LSB 8
`define COD_ST_PWR_LSB 12
`define COD_ST_LOCK 16
`define COD_ST_PIN 17

`define COD_CLK_PERIOD_NS 5
`define COD_SYNC_MIN_NS 50000
`define COD_SYNC_CNT_W 20

`endif

// >>> design/cod_pkg.sv
// Types shared by the output clock block.
// Assumes the constants of cod_regs.svh.
package cod_pkg;

    typedef enum logic [5:0] {
        COD_S_PWR = 6'h01,
        COD_S_CFG = 6'h02,
        COD_S_SYNC = 6'h04,
        COD_S_LOCK = 6'h08,
        COD_S_RUN = 6'h10,
        COD_S_RESYNC = 6'h20
    } cod_state_t;

endpackage : cod_pkg

// >>> design/cod_out_channel.sv
// One output channel: integer divider, glitch-free enable and driver leg control.
// Assumes all control inputs are synchronous to clk.
`timescale 1ns/100ps
`include "cod_regs.svh"

module cod_out_channel import cod_pkg::*; #(
    parameter int DIV_W = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [DIV_W-1:0] ratio,
    input wire logic [1:0] out_type,
    input wire logic [1:0] cmos_leg,
    input wire logic [1:0] dis_state,
    input wire logic [3:0] hcsl_swing,
    input wire logic [3:0] lvds_amp,
    input wire logic drv_on,
    input wire logic hold,
    input wire logic en_req,
    output logic leg_p,
    output logic leg_n,
    output logic oe_p,
    output logic oe_n,
    output logic enabled,
    output logic [3:0] swing
);

    logic [DIV_W-1:0] cnt;
    logic q;
    logic [DIV_W-1:0] next_cnt;
    logic next_q;
    logic next_enabled;
    logic next_leg_p;
    logic next_leg_n;
    logic next_oe_p;
    logic next_oe_n;
    logic [3:0] next_swing;
    logic [DIV_W-1:0] eff;

    always_comb begin
        eff = (ratio < DIV_W'(2)) ? DIV_W'(2) : ratio;
        // Counter restarts at zero on every channel together.
        if (hold) begin // RULE_04
            next_cnt = '0;
            next_q = 1'b0; // RULE_05
        end else begin
            next_cnt = (cnt >= eff - DIV_W'(1)) ? '0 : cnt + DIV_W'(1); // RULE_01 RULE_02
            next_q = next_cnt < (eff >> 1);
        end
        // A new en_req decision lands only while the clock is low; power-down clears enabled at once.
        if (!drv_on) begin
            next_enabled = 1'b0; // RULE_10
        end else if (!q) begin
            next_enabled = en_req; // RULE_03 RULE_16
        end else begin
            next_enabled = enabled;
        end
        next_leg_p = 1'b0;
        next_leg_n = 1'b0;
        next_oe_p = 1'b0;
        next_oe_n = 1'b0;
        if (!drv_on) begin
            next_oe_p = 1'b0; // RULE_10 RULE_11
        end else if (!next_enabled) begin
            next_oe_p = dis_state != `COD_DIS_TRI; // RULE_09
            next_oe_n = dis_state != `COD_DIS_TRI;
            next_leg_p = dis_state == `COD_DIS_HIGH;
            next_leg_n = dis_state == `COD_DIS_HIGH;
        end else if (out_type == `COD_TYPE_LVCMOS) begin
            next_leg_p = next_q; // RULE_06
            next_leg_n = next_q;
            next_oe_p = cmos_leg[`COD_LEG_TRUE]; // RULE_08
            next_oe_n = cmos_leg[`COD_LEG_COMP];
        end else begin
            next_leg_p = next_q; // RULE_06
            next_leg_n = ~next_q;
            next_oe_p = 1'b1;
            next_oe_n = 1'b1;
        end
        if (out_type == `COD_TYPE_LVDS) begin
            next_swing = lvds_amp; // RULE_07
        end else if (out_type == `COD_TYPE_HCSL) begin
            next_swing = hcsl_swing;
        end else begin
            next_swing = 4'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt <= '0;
            q <= 1'b0;
            enabled <= 1'b0;
            leg_p <= 1'b0;
            leg_n <= 1'b0;
            oe_p <= 1'b0;
            oe_n <= 1'b0;
            swing <= 4'h0;
        end else begin
            cnt <= next_cnt;
            q <= next_q;
            enabled <= next_enabled;
            leg_p <= next_leg_p;
            leg_n <= next_leg_n;
            oe_p <= next_oe_p;
            oe_n <= next_oe_n;
            swing <= next_swing;
        end
    end

endmodule : cod_out_channel

// >>> design/cod_top.sv
// Output divider and enable control: four dividers, sync, startup and run-time enables.
// Assumes an Avalon-MM master on REF_CLK and asynchronous status pins from the analog side.
//
// Contract
// RULE_01: Four independent integer dividers divide the VCO clock, one per output.
// RULE_02: Each divider's ratio comes from its programmable divide-ratio field.
// RULE_03: Enable and disable changes act synchronously to the output clock, no runts.
// RULE_04: Dividers sync automatically at startup; software may trigger a resync later.
// RULE_05: Sync stops the clocks 50 to 300 us; drivers stay disabled during startup sync.
// RULE_06: Each driver runs as HCSL, LVDS or LVCMOS per its type field.
// RULE_07: Swing comes from the HCSL swing field or LVDS amplitude field by type.
// RULE_08: In LVCMOS the true, complement or both legs are active per leg select.
// RULE_09: Disabled output holds legs low by default, or high or tristate per field.
// RULE_10: Power-down bit tristates both legs and makes enable requests ignored.
// RULE_11: Until supplies are stable legs are tristated, then disabled low.
// RULE_12: After configuration load, gating waits for PLL lock or enables at once.
// RULE_13: After startup, PLL lock changes no longer affect the drivers.
// RULE_14: With source select 1, each disable bit alone enables or disables its output.
// RULE_15: With source select 0, the pin gates all powered outputs with their disable bits.
// RULE_16: Enable decisions apply only while the divided clock is low.
//
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "cod_regs.svh"

module cod_top import cod_pkg::*; #(
    parameter int DIV_W = 8,
    parameter int unsigned SYNC_CYCLES =
        (`COD_SYNC_MIN_NS + `COD_CLK_PERIOD_NS - 1) / `COD_CLK_PERIOD_NS
) (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic [`COD_ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic SUPPLY_STABLE,
    input wire logic CFG_LOAD_DONE,
    input wire logic APLL_LOCK,
    input wire logic SHARED_ENABLE_SELECT_PIN,
    output logic [`COD_NUM_OUT-1:0] OUT_P,
    output logic [`COD_NUM_OUT-1:0] OUT_N,
    output logic [`COD_NUM_OUT-1:0] OUT_P_OE,
    output logic [`COD_NUM_OUT-1:0] OUT_N_OE,
    output logic [`COD_NUM_OUT*4-1:0] OUT_SWING,
    output logic [`COD_NUM_OUT*2-1:0] OUT_TYPE
);

    localparam int NOUT = `COD_NUM_OUT;
    localparam int NSYNC = 4;
    localparam int SY_SUPPLY = 0;
    localparam int SY_CFG = 1;
    localparam int SY_LOCK = 2;
    localparam int SY_PIN = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: a change counts once the second and third stages agree.

    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sy1;
    logic [NSYNC-1:0] sy2;
    logic [NSYNC-1:0] sy3;
    logic [NSYNC-1:0] sy_val;
    logic [NSYNC-1:0] next_sy_val;

    assign pin_raw = {SHARED_ENABLE_SELECT_PIN, APLL_LOCK, CFG_LOAD_DONE, SUPPLY_STABLE};

    genvar gs;
    generate
        for (gs = 0; gs < NSYNC; gs++) begin : g_sync
            always_comb begin
                next_sy_val[gs] = (sy2[gs] == sy3[gs]) ? sy3[gs] : sy_val[gs];
            end
        end
    endgenerate

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            sy1 <= '0;
            sy2 <= '0;
            sy3 <= '0;
            sy_val <= '0;
        end else begin
            sy1 <= pin_raw;
            sy2 <= sy1;
            sy3 <= sy2;
            sy_val <= next_sy_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register file and Avalon-MM slave with one wait state on every access.

    logic ack;
    logic next_ack;
    logic [1:0] ctrl;
    logic [1:0] next_ctrl;
    logic [`COD_CFG_W-1:0] cfg [NOUT];
    logic [`COD_CFG_W-1:0] next_cfg [NOUT];
    logic [31:0] next_readdata;
    logic [31:0] rd_mux;
    logic [31:0] status;
    logic [31:0] be_mask;
    logic do_wr;
    logic hit_ctrl;
    logic hit_status;
    logic hit_cfg;
    logic [1:0] cfg_idx;
    logic sync_req;
    logic [NOUT-1:0] enabled;
    logic [NOUT-1:0] drv_on;
    cod_state_t state;
    cod_state_t next_state;

    // A request still held after its accepting edge is taken again after one more wait state.
    // The master must therefore drop read or write right after the edge that completes it.
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack;
    assign do_wr = AVS_WRITE & ack;
    assign be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                      {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
    assign hit_ctrl = AVS_ADDRESS == `COD_CTRL_OFS;
    assign hit_status = AVS_ADDRESS == `COD_STATUS_OFS;
    assign hit_cfg = (AVS_ADDRESS[7:4] == `COD_OUT_CFG_HI) && (AVS_ADDRESS[1:0] == 2'h0);
    assign cfg_idx = AVS_ADDRESS[3:2];
    // Manual resync is accepted only once startup has finished.
    assign sync_req = do_wr && hit_ctrl && AVS_BYTEENABLE[0]
                      && AVS_WRITEDATA[`COD_CTRL_DIV_SYNC] && (state == COD_S_RUN); // RULE_04

    always_comb begin
        status = 32'h0;
        status[5:0] = state;
        status[`COD_ST_EN_LSB +: NOUT] = enabled;
        status[`COD_ST_PWR_LSB +: NOUT] = drv_on;
        status[`COD_ST_LOCK] = sy_val[SY_LOCK];
        status[`COD_ST_PIN] = sy_val[SY_PIN];
    end

    always_comb begin
        next_ack = (AVS_READ | AVS_WRITE) & ~ack;
        next_ctrl = ctrl;
        for (int i = 0; i < NOUT; i++) begin
            next_cfg[i] = cfg[i];
        end
        if (hit_ctrl) begin
            rd_mux = {30'h0, ctrl};
        end else if (hit_status) begin
            rd_mux = status;
        end else if (hit_cfg) begin
            rd_mux = {8'h0, cfg[cfg_idx]};
        end else begin
            rd_mux = 32'h0;
        end
        if (do_wr && hit_ctrl) begin
            next_ctrl = (ctrl & ~be_mask[1:0]) | (AVS_WRITEDATA[1:0] & be_mask[1:0]);
        end else if (do_wr && hit_cfg) begin
            next_cfg[cfg_idx] = (cfg[cfg_idx] & ~be_mask[`COD_CFG_W-1:0])
                                | (AVS_WRITEDATA[`COD_CFG_W-1:0] & be_mask[`COD_CFG_W-1:0]);
        end
        next_readdata = (AVS_READ && !ack) ? rd_mux : AVS_READDATA;
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            ack <= 1'b0;
            ctrl <= `COD_CTRL_RESET;
            AVS_READDATA <= 32'h0;
            for (int i = 0; i < NOUT; i++) begin
                cfg[i] <= `COD_CFG_RESET;
            end
        end else begin
            ack <= next_ack;
            ctrl <= next_ctrl;
            AVS_READDATA <= next_readdata;
            for (int i = 0; i < NOUT; i++) begin
                cfg[i] <= next_cfg[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Startup sequencer and divider sync timer.

    logic [`COD_SYNC_CNT_W-1:0] scnt;
    logic [`COD_SYNC_CNT_W-1:0] next_scnt;
    logic sync_done;

    assign sync_done = scnt == '0;

    always_comb begin
        next_state = state;
        case (state)
            COD_S_PWR: begin
                if (sy_val[SY_SUPPLY]) begin
                    next_state = COD_S_CFG; // RULE_11
                end
            end
            COD_S_CFG: begin
                if (sy_val[SY_CFG]) begin
                    next_state = COD_S_SYNC; // RULE_04
                end
            end
            COD_S_SYNC: begin
                if (sync_done && ctrl[`COD_CTRL_STARTUP_GATE]) begin
                    next_state = COD_S_LOCK; // RULE_12
                end else if (sync_done) begin
                    next_state = COD_S_RUN; // RULE_12
                end
            end
            COD_S_LOCK: begin
                if (sy_val[SY_LOCK]) begin
                    next_state = COD_S_RUN; // RULE_12
                end
            end
            COD_S_RUN: begin
                // Lock is no longer looked at once running.
                if (sync_req) begin
                    next_state = COD_S_RESYNC; // RULE_04 RULE_13
                end
            end
            COD_S_RESYNC: begin
                if (sync_done) begin
                    next_state = COD_S_RUN;
                end
            end
            default: begin
                next_state = COD_S_PWR;
            end
        endcase
        if ((next_state == COD_S_SYNC || next_state == COD_S_RESYNC) && next_state != state) begin
            next_scnt = `COD_SYNC_CNT_W'(SYNC_CYCLES - 1); // RULE_05
        end else if (!sync_done) begin
            next_scnt = scnt - `COD_SYNC_CNT_W'(1);
        end else begin
            next_scnt = scnt;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            state <= COD_S_PWR;
            scnt <= '0;
        end else begin
            state <= next_state;
            scnt <= next_scnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output channels with enable source selection.

    logic running;
    logic hold;
    logic [NOUT-1:0] en_req;

    // Outputs stay enabled through a manual resync, so its stop is visible.
    assign running = (state == COD_S_RUN) || (state == COD_S_RESYNC); // RULE_05
    assign hold = (state == COD_S_SYNC) || (state == COD_S_RESYNC); // RULE_05

    genvar gc;
    generate
        for (gc = 0; gc < NOUT; gc++) begin : g_out
            assign drv_on[gc] = (state != COD_S_PWR) && !cfg[gc][`COD_F_PD]; // RULE_10 RULE_11
            assign en_req[gc] = running && !cfg[gc][`COD_F_DIS] // RULE_14
                                && (ctrl[`COD_CTRL_OE_SEL] || sy_val[SY_PIN]); // RULE_15

            cod_out_channel #(
                .DIV_W(DIV_W)
            ) u_chan (
                .clk(REF_CLK),
                .srst(SRST),
                .ratio(cfg[gc][`COD_F_RATIO_LSB +: DIV_W]), // RULE_02
                .out_type(cfg[gc][`COD_F_TYPE_LSB +: 2]),
                .cmos_leg(cfg[gc][`COD_F_LEG_LSB +: 2]),
                .dis_state(cfg[gc][`COD_F_DISST_LSB +: 2]),
                .hcsl_swing(cfg[gc][`COD_F_HSW_LSB +: 4]),
                .lvds_amp(cfg[gc][`COD_F_LAMP_LSB +: 4]),
                .drv_on(drv_on[gc]),
                .hold(hold),
                .en_req(en_req[gc]),
                .leg_p(OUT_P[gc]),
                .leg_n(OUT_N[gc]),
                .oe_p(OUT_P_OE[gc]),
                .oe_n(OUT_N_OE[gc]),
                .enabled(enabled[gc]),
                .swing(OUT_SWING[gc*4 +: 4])
            );
        end
    endgenerate

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            OUT_TYPE <= '0;
        end else begin
            for (int i = 0; i < NOUT; i++) begin
                OUT_TYPE[i*2 +: 2] <= cfg[i][`COD_F_TYPE_LSB +: 2]; // RULE_06
            end
        end
    end

endmodule : cod_top

// >>> test/cod_assertions.sv
// Checker for the output divider and enable block, bound to every cod_top instance.
// Assumes the port names of cod_top and the single REF_CLK domain.
`timescale 1ns/100ps
module cod_assertions (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic SUPPLY_STABLE,
    input wire logic CFG_LOAD_DONE,
    input wire logic [3:0] OUT_P,
    input wire logic [3:0] OUT_N,
    input wire logic [3:0] OUT_P_OE,
    input wire logic [3:0] OUT_N_OE,
    input wire logic [15:0] OUT_SWING,
    input wire logic [7:0] OUT_TYPE
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    sequence s_req;
        $rose(AVS_READ || AVS_WRITE);
    endsequence
    sequence s_ack;
        !AVS_WAITREQUEST && (AVS_READ || AVS_WRITE);
    endsequence
    sequence s_cmos;
        OUT_TYPE[1:0] == 2'h2 && $stable(OUT_TYPE);
    endsequence
    a_bus_one_wait: assert property (s_req |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("waitrequest not low exactly one cycle after request");
    a_bus_release: assert property (s_ack |=> AVS_WAITREQUEST || !(AVS_READ || AVS_WRITE))
        else $error("waitrequest low for two cycles in one access");
    a_rdata_hold: assert property (!AVS_READ |=> $stable(AVS_READDATA))
        else $error("read data changed without a read");
    a_reset_quiet: assert property (
        disable iff (1'h0) SRST |=> (OUT_P_OE | OUT_N_OE | OUT_P | OUT_N) == 4'h0)
        else $error("outputs active after reset");
    a_supply_gate: assert property (
        (!SUPPLY_STABLE) [*4] |-> (OUT_P_OE | OUT_N_OE) == 4'h0)
        else $error("leg driven before supplies are stable");
    a_sync_quiet: assert property ($rose(CFG_LOAD_DONE) |-> (OUT_P == 4'h0) [*8])
        else $error("output toggled during startup sync");
    a_cmos_phase: assert property (
        s_cmos ##0 (OUT_P_OE[0] && OUT_N_OE[0]) |-> OUT_P[0] == OUT_N[0])
        else $error("LVCMOS legs out of phase");
    a_cmos_swing: assert property (s_cmos |-> OUT_SWING[3:0] == 4'h0)
        else $error("swing not zero in LVCMOS");
    a_oe_pair: assert property (
        (OUT_TYPE[1:0] != 2'h2 && $stable(OUT_TYPE)) |-> OUT_P_OE[0] == OUT_N_OE[0])
        else $error("differential legs enabled apart");
endmodule : cod_assertions

bind cod_top cod_assertions i_chk (.REF_CLK, .SRST, .AVS_READ, .AVS_WRITE, .AVS_READDATA,
    .AVS_WAITREQUEST, .SUPPLY_STABLE, .CFG_LOAD_DONE, .OUT_P, .OUT_N, .OUT_P_OE, .OUT_N_OE,
    .OUT_SWING, .OUT_TYPE);

// >>> test/cod_rx.sv
// Downstream clock receiver: measures period, high time and rising edges of one leg.
// Assumes one sample per clock edge; a released leg reads low through the termination.
`timescale 1ns/100ps
module cod_rx (
    input wire logic clk,
    input wire logic p,
    input wire logic oe,
    output int per,
    output int hi,
    output int rises
);
    int cnt = 0;
    int hc = 0;
    logic prev = 1'h0;
    logic lvl;
    assign lvl = oe & p;
    initial begin
        per = 0;
        hi = 0;
        rises = 0;
    end
    always @(posedge clk) begin
        prev <= lvl;
        cnt <= cnt + 1;
        hc <= hc + 1;
        if (lvl && !prev) begin
            per <= cnt;
            cnt <= 1;
            rises <= rises + 1;
            hc <= 1;
        end
        if (!lvl && prev) begin
            hi <= hc;
        end
    end
endmodule : cod_rx

// >>> test/clock_output_divider_enable_ctrl_tb.sv
// Self-checking bench: startup, ratios, enables, levels, types, power-down, manual sync.
// Assumes cod_top with a short sync time and four receivers on the true legs.
`timescale 1ns/100ps
`include "cod_regs.svh"
module clock_output_divider_enable_ctrl_tb import cod_pkg::*;;
    localparam int SC = 20;
    logic REF_CLK = 1'h0, SRST = 1'h1, AVS_READ = 1'h0, AVS_WRITE = 1'h0, APLL_LOCK = 1'h0;
    logic SUPPLY_STABLE = 1'h0, CFG_LOAD_DONE = 1'h0, SHARED_ENABLE_SELECT_PIN = 1'h0;
    logic [7:0] AVS_ADDRESS = 8'h00;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, q;
    logic [31:0] s = 32'h3E82;
    logic [3:0] AVS_BYTEENABLE = 4'hF;
    logic AVS_WAITREQUEST;
    logic [3:0] OUT_P, OUT_N, OUT_P_OE, OUT_N_OE, h, a;
    logic [15:0] OUT_SWING;
    logic [7:0] OUT_TYPE;
    logic [7:0] r[4];
    logic [1:0] t, l;
    int miscompares = 0, checked = 0, cyc = 0, t0 = 0;
    int per[4], hi[4], rs[4], sr[4];

    cod_top #(.SYNC_CYCLES(SC)) i_dut (.REF_CLK, .SRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
        .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .SUPPLY_STABLE,
        .CFG_LOAD_DONE, .APLL_LOCK, .SHARED_ENABLE_SELECT_PIN, .OUT_P, .OUT_N, .OUT_P_OE,
        .OUT_N_OE, .OUT_SWING, .OUT_TYPE);
    for (genvar g = 0; g < 4; g++) begin : g_rx
        cod_rx i_rx (.clk(REF_CLK), .p(OUT_P[g]), .oe(OUT_P_OE[g]), .per(per[g]), .hi(hi[g]),
            .rises(rs[g]));
    end
    initial begin
        forever #2.5 REF_CLK = ~REF_CLK;
    end
    always @(posedge REF_CLK) cyc <= cyc + 1;

////////////////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs
    function automatic logic [31:0] mk(input logic [7:0] ra, input logic [1:0] ty,
        input logic [1:0] lg, input logic [1:0] ds, input logic pd, input logic dis,
        input logic [3:0] hs, input logic [3:0] la);
        return {8'h00, la, hs, dis, pd, ds, lg, ty, ra};
    endfunction : mk
    task automatic wrap_up();
        $display("Counts: checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Holds the request until waitrequest is sampled low; read data is taken at that edge.
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        @(posedge REF_CLK);
        AVS_ADDRESS <= ad;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= w;
        AVS_READ <= ~w;
        n = 0;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (AVS_WAITREQUEST !== 1'h0 && n < 50);
        if (n >= 50) begin
            miscompares++;
            wrap_up();
        end
        q = AVS_READDATA;
        AVS_READ <= 1'h0;
        AVS_WRITE <= 1'h0;
    endtask : bus
    task automatic wait_st(input logic [5:0] st);
        int n;
        n = 0;
        do begin
            bus(1'h0, 8'h04, 32'h0);
            n++;
        end while (q[5:0] !== st && n < 100);
        chk(q[5:0], st);
        if (q[5:0] !== st) begin
            wrap_up();
        end
    endtask : wait_st
    task automatic boot(input logic g);
        SRST <= 1'h1;
        SUPPLY_STABLE <= 1'h0;
        CFG_LOAD_DONE <= 1'h0;
        APLL_LOCK <= 1'h0;
        repeat (2) @(posedge REF_CLK);
        SRST <= 1'h0;
        wait_st(COD_S_PWR);
        chk({OUT_P_OE, OUT_N_OE}, 8'h00);
        bus(1'h1, 8'h00, {30'h0, g, 1'h0});
        SUPPLY_STABLE <= 1'h1;
        wait_st(COD_S_CFG);
        chk({OUT_P_OE, OUT_P}, 8'hF0);
        t0 = cyc;
        CFG_LOAD_DONE <= 1'h1;
        wait_st(g ? COD_S_LOCK : COD_S_RUN);
        chk(cyc - t0 >= SC, 1);
        chk(cyc - t0 <= 6 * SC, 1);
        chk(OUT_P, 4'h0);
    endtask : boot

////////////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        boot(1'h0);
        bus(1'h0, 8'h10, 32'h0);
        chk(q, 32'h000C04);
        AVS_BYTEENABLE <= 4'h1;
        bus(1'h1, 8'h10, 32'hFFFFFFFF);
        AVS_BYTEENABLE <= 4'hF;
        bus(1'h0, 8'h10, 32'h0);
        chk(q, 32'h000CFF);
        bus(1'h0, 8'h08, 32'h0);
        chk(q, 32'h0);
        $display("test startup without lock gate done");
        boot(1'h1);
        repeat (30) @(posedge REF_CLK);
        chk(OUT_P, 4'h0);
        APLL_LOCK <= 1'h1;
        wait_st(COD_S_RUN);
        APLL_LOCK <= 1'h0;
        repeat (10) @(posedge REF_CLK);
        bus(1'h0, 8'h04, 32'h0);
        chk(q[5:0], COD_S_RUN);
        $display("test lock gated startup done");
        for (int i = 0; i < 4; i++) begin
            r[i] = (i == 0) ? 8'h02 : (i == 3) ? 8'hFF : 8'h04 + 8'(xs() % 13);
            bus(1'h1, 8'h10 + 8'(4 * i), mk(r[i], 2'h0, 2'h3, 2'h0, 1'h0, 1'h0, 4'h0, 4'h0));
        end
        SHARED_ENABLE_SELECT_PIN <= 1'h1;
        repeat (800) @(posedge REF_CLK);
        for (int i = 0; i < 4; i++) begin
            chk(per[i], r[i]);
            chk(hi[i], r[i] / 2);
        end
        $display("test divide ratios done");
        SHARED_ENABLE_SELECT_PIN <= 1'h0;
        repeat (300) @(posedge REF_CLK);
        sr = rs;
        repeat (300) @(posedge REF_CLK);
        for (int i = 0; i < 4; i++) begin
            chk(rs[i] - sr[i], 0);
            chk(hi[i], r[i] / 2);
        end
        chk(OUT_P, 4'h0);
        $display("test pin disable done");
        bus(1'h1, 8'h00, 32'h3);
        bus(1'h1, 8'h1C, mk(8'h04, 2'h0, 2'h3, 2'h0, 1'h0, 1'h1, 4'h0, 4'h0));
        repeat (100) @(posedge REF_CLK);
        sr = rs;
        repeat (100) @(posedge REF_CLK);
        for (int i = 0; i < 4; i++) begin
            chk(rs[i] != sr[i], i != 3);
        end
        for (int d = 0; d < 3; d++) begin
            bus(1'h1, 8'h1C, mk(8'h04, 2'h0, 2'h3, 2'(d), 1'h0, 1'h1, 4'h0, 4'h0));
            repeat (10) @(posedge REF_CLK);
            chk({OUT_P_OE[3], OUT_N_OE[3], OUT_P[3] & OUT_P_OE[3], OUT_N[3] & OUT_N_OE[3]},
                (d == 0) ? 4'hC : (d == 1) ? 4'hF : 4'h0);
        end
        $display("test per-output enable and levels done");
        for (int k = 0; k < 5; k++) begin
            t = (k < 2) ? 2'(k) : 2'h2;
            l = (k < 2) ? 2'h3 : 2'(k - 1);
            h = 4'(xs());
            a = 4'(xs());
            bus(1'h1, 8'h10, mk(8'h02, t, l, 2'h0, 1'h0, 1'h0, h, a));
            repeat (10) @(posedge REF_CLK);
            chk(OUT_TYPE[1:0], t);
            chk(OUT_SWING[3:0], (t == 2'h0) ? h : (t == 2'h1) ? a : 4'h0);
            chk({OUT_P_OE[0], OUT_N_OE[0]}, {l[0], l[1]});
        end
        bus(1'h1, 8'h18, mk(r[2], 2'h0, 2'h3, 2'h0, 1'h1, 1'h0, 4'h0, 4'h0));
        repeat (10) @(posedge REF_CLK);
        sr = rs;
        chk({OUT_P_OE[2], OUT_N_OE[2]}, 2'h0);
        repeat (100) @(posedge REF_CLK);
        chk(rs[2] - sr[2], 0);
        $display("test types and power-down done");
        bus(1'h1, 8'h00, 32'h7);
        bus(1'h0, 8'h00, 32'h0);
        chk(q[2:0], 3'h3);
        bus(1'h0, 8'h04, 32'h0);
        chk(q[5:0], COD_S_RESYNC);
        sr = rs;
        repeat (SC - 12) @(posedge REF_CLK);
        chk(rs[1] - sr[1], 0);
        wait_st(COD_S_RUN);
        repeat (50) @(posedge REF_CLK);
        chk(rs[1] != sr[1], 1);
        $display("test manual sync done");
        wrap_up();
    end
endmodule : clock_output_divider_enable_ctrl_tb
